/* File: hdl/dual_port_pin_function_mux.sv */
// Two 8-bit digital I/O ports with peripheral function muxing
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
// Behaviour
// - With function select on port 1 bits 0-3, bit 0 drives low and feeds the timer external clock, bits 1-3 drive compare outputs 0-2 and feed capture inputs A 0-2.
// - With function select on port 1 bits 4-7, bit 4 outputs the subsystem clock and bits 5-7 compare outputs 0-2, with no input to any module.
// - With function select on port 2 bits 0-4, bit 0 outputs the auxiliary clock, bit 1 drives low and feeds the alternate timer clock, bits 2-4 output compares 0-2, bits 2-3 feed capture inputs B 0-1.
// - While the external resistor select is set, port 2 bit 5 is cut from its pad, its module output is low and it feeds no module.
// - Port 2 bits 6 and 7 keep all control bits without pads, with a low module output and no module input.
// - The interrupt flags of port 2 bits 6 and 7 change only by software writes.
// - Pin direction comes from the direction bit, except port 2 bit 5, which the external resistor select forces to input.
module dual_port_pin_function_mux
  import pin_mux_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM register slave
  input wire logic [ADDR_WIDTH-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Port 1 pads
  input wire logic [7:0] pin1_in_i,
  output logic [7:0] pin1_out_o,
  output logic [7:0] pin1_oe_n_o,
  // Port 2 pads, bits 0 to 5
  input wire logic [PORT2_PINS-1:0] pin2_in_i,
  output logic [PORT2_PINS-1:0] pin2_out_o,
  output logic [PORT2_PINS-1:0] pin2_oe_n_o,
  // Timer and clock module
  input wire logic compare_output_0_i,
  input wire logic compare_output_1_i,
  input wire logic compare_output_2_i,
  input wire logic subsystem_clock_i,
  input wire logic aux_clock_i,
  input wire logic ext_resistor_osc_select_i,
  output logic timer_ext_clock_in_o,
  output logic timer_alt_clock_in_o,
  output logic capture_in_ch0_a_o,
  output logic capture_in_ch1_a_o,
  output logic capture_in_ch2_a_o,
  output logic capture_in_ch0_b_o,
  output logic capture_in_ch1_b_o,
  // Interrupt requests, one per port
  output logic port1_irq_o,
  output logic port2_irq_o
);

  // Elaboration check: the synchroniser depth is fixed at two flops
  if (SYNC_STAGES != 2) begin : g_sync_check
    $error("SYNC_STAGES must be 2");
  end

  state_type st_r;
  state_type st_nxt;

  logic [1:0][7:0] pad_in;
  logic [1:0][7:0] module_out;
  logic [1:0][7:0] edge_mask;
  logic [2:0] compare_out;
  logic port_sel;
  logic [2:0] reg_idx;
  logic wr_take;
  logic rd_start;
  logic [7:0] wdata;

  //////////////////////////////////////////////////////////////////////////
  // Pad and module routing
  always_comb begin
    compare_out = {compare_output_2_i, compare_output_1_i,
      compare_output_0_i};
    pad_in[0] = pin1_in_i;
    // Unbonded bits read as zero; a cut pad feeds nothing in
    pad_in[1] = {2'b00, pin2_in_i};
    if (ext_resistor_osc_select_i) begin
      pad_in[1][OSC_RES_BIT] = 1'b0;
    end
    module_out[0] = {compare_out, subsystem_clock_i, compare_out,
      1'b0};
    // Bits 5 to 7 of port 2 carry a constant low
    module_out[1] = {3'b000, compare_out, 1'b0, aux_clock_i};
    edge_mask[0] = 8'hff;
    edge_mask[1] = PORT2_EDGE_MASK;
    if (ext_resistor_osc_select_i) begin
      edge_mask[1][OSC_RES_BIT] = 1'b0;
    end
  end

  assign port_sel = avs_address_i[PORT_ADDR_BIT];
  assign reg_idx = avs_address_i[2:0];
  // A write lands on the one edge where waitrequest is seen low
  assign wr_take = avs_write_i && !st_r.waitrequest;
  assign rd_start = avs_read_i && st_r.waitrequest;
  assign wdata = avs_writedata_i[7:0];

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [7:0] edge_seen;
    logic [7:0] sel;
    edge_seen = 8'h00;
    sel = 8'h00;
    st_nxt = st_r;
    // Two-flop synchronisers; meta is read only by sync
    st_nxt.meta = pad_in;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;

    for (int p = 0; p < 2; p++) begin
      // Rising when edge select clear, falling when set
      edge_seen = ((st_r.sync[p] & ~st_r.prev[p] &
        ~st_r.port[p].pin_edge_select) |
        (~st_r.sync[p] & st_r.prev[p] &
        st_r.port[p].pin_edge_select)) & edge_mask[p];
      if (wr_take && avs_byteenable_i[0] && (port_sel == p[0])) begin
        unique case (reg_idx)
          REG_OUTPUT: st_nxt.port[p].pin_output_value = wdata;
          REG_DIRECTION: st_nxt.port[p].pin_direction = wdata;
          REG_IRQ_FLAG: st_nxt.port[p].pin_irq_flag = wdata;
          REG_EDGE_SELECT: st_nxt.port[p].pin_edge_select = wdata;
          REG_IRQ_ENABLE: st_nxt.port[p].pin_irq_enable = wdata;
          REG_FUNCTION_SELECT: st_nxt.port[p].pin_function_select = wdata;
          default: ;
        endcase
      end
      // A pad edge wins over a clearing write in the same cycle
      st_nxt.port[p].pin_irq_flag = st_nxt.port[p].pin_irq_flag |
        edge_seen;
      st_nxt.irq[p] = |(st_nxt.port[p].pin_irq_flag &
        st_nxt.port[p].pin_irq_enable);

      sel = st_r.port[p].pin_function_select;
      st_nxt.pin_out[p] = (sel & module_out[p]) |
        (~sel & st_r.port[p].pin_output_value);
      st_nxt.pin_oe_n[p] = ~st_r.port[p].pin_direction;
    end
    if (ext_resistor_osc_select_i) begin
      st_nxt.pin_out[1][OSC_RES_BIT] = 1'b0;
      st_nxt.pin_oe_n[1][OSC_RES_BIT] = 1'b1;
    end

    // Module inputs: only the selected pins feed the timer
    st_nxt.timer.timer_ext_clock_in = st_r.port[0].pin_function_select[0]
      & st_r.sync[0][0];
    st_nxt.timer.capture_in_a = st_r.port[0].pin_function_select[3:1]
      & st_r.sync[0][3:1];
    st_nxt.timer.timer_alt_clock_in = st_r.port[1].pin_function_select[1]
      & st_r.sync[1][1];
    st_nxt.timer.capture_in_b = st_r.port[1].pin_function_select[3:2]
      & st_r.sync[1][3:2];

    // Bus: waitrequest drops for exactly one cycle per request
    if (!st_r.waitrequest) begin
      st_nxt.waitrequest = 1'b1;
    end else if (avs_read_i || avs_write_i) begin
      st_nxt.waitrequest = 1'b0;
    end
    if (rd_start) begin
      st_nxt.readdata = READ_DEFAULT;
      unique case (reg_idx)
        REG_INPUT: st_nxt.readdata[7:0] = st_r.sync[port_sel];
        REG_OUTPUT:
          st_nxt.readdata[7:0] = st_r.port[port_sel].pin_output_value;
        REG_DIRECTION:
          st_nxt.readdata[7:0] = st_r.port[port_sel].pin_direction;
        REG_IRQ_FLAG:
          st_nxt.readdata[7:0] = st_r.port[port_sel].pin_irq_flag;
        REG_EDGE_SELECT:
          st_nxt.readdata[7:0] = st_r.port[port_sel].pin_edge_select;
        REG_IRQ_ENABLE:
          st_nxt.readdata[7:0] = st_r.port[port_sel].pin_irq_enable;
        REG_FUNCTION_SELECT:
          st_nxt.readdata[7:0] = st_r.port[port_sel].pin_function_select;
        default: st_nxt.readdata = READ_DEFAULT;
      endcase
    end

    if (rst_i) begin
      st_nxt = '0;
      for (int p = 0; p < 2; p++) begin
        st_nxt.port[p] = {6{CTL_RESET}};
        st_nxt.pin_oe_n[p] = 8'hff;
      end
      st_nxt.waitrequest = 1'b1;
      // Synchronisers run on through reset, so a pad held high is
      // not taken for a fresh edge once reset drops
      st_nxt.meta = pad_in;
      st_nxt.sync = st_r.meta;
      st_nxt.prev = st_r.sync;
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata_o = st_r.readdata;
  assign avs_waitrequest_o = st_r.waitrequest;
  assign pin1_out_o = st_r.pin_out[0];
  assign pin1_oe_n_o = st_r.pin_oe_n[0];
  assign pin2_out_o = st_r.pin_out[1][PORT2_PINS-1:0];
  assign pin2_oe_n_o = st_r.pin_oe_n[1][PORT2_PINS-1:0];
  assign timer_ext_clock_in_o = st_r.timer.timer_ext_clock_in;
  assign timer_alt_clock_in_o = st_r.timer.timer_alt_clock_in;
  assign capture_in_ch0_a_o = st_r.timer.capture_in_a[0];
  assign capture_in_ch1_a_o = st_r.timer.capture_in_a[1];
  assign capture_in_ch2_a_o = st_r.timer.capture_in_a[2];
  assign capture_in_ch0_b_o = st_r.timer.capture_in_b[0];
  assign capture_in_ch1_b_o = st_r.timer.capture_in_b[1];
  assign port1_irq_o = st_r.irq[0];
  assign port2_irq_o = st_r.irq[1];

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  dir_drives_oe_a: assert property (
    ##1 pin1_oe_n_o == ~$past(st_r.port[0].pin_direction))
    else $error("port 1 enable not from direction bit");

  p1_bit0_low_a: assert property (
    $past(st_r.port[0].pin_function_select[0]) |-> !pin1_out_o[0])
    else $error("port 1 bit 0 not low in function mode");

  p1_compare_a: assert property (
    $past(st_r.port[0].pin_function_select[2]) |->
      pin1_out_o[2] == $past(compare_output_1_i))
    else $error("port 1 bit 2 not compare 1");

  p1_subclk_a: assert property (
    $past(st_r.port[0].pin_function_select[4]) |->
      pin1_out_o[4] == $past(subsystem_clock_i))
    else $error("port 1 bit 4 not subsystem clock");

  p2_alt_clock_a: assert property (
    st_r.port[1].pin_function_select[1] && st_r.sync[1][1] |=>
      timer_alt_clock_in_o && !pin2_out_o[1])
    else $error("port 2 bit 1 routing wrong");

  osc_cut_a: assert property (
    $past(ext_resistor_osc_select_i) |->
      pin2_oe_n_o[OSC_RES_BIT] && !pin2_out_o[OSC_RES_BIT])
    else $error("port 2 bit 5 still on its pad");

  soft_flag_a: assert property (
    !$past(wr_take && port_sel && reg_idx == REG_IRQ_FLAG) |->
      $stable(st_r.port[1].pin_irq_flag[7:6]))
    else $error("unbonded flag moved without a write");

  rise_sets_flag_a: assert property (
    ($rose(pin1_in_i[0]) && !st_r.port[0].pin_edge_select[0])
    ##1 (pin1_in_i[0] && !st_r.port[0].pin_edge_select[0]) [*2]
    |-> ##1 st_r.port[0].pin_irq_flag[0])
    else $error("rising edge did not set flag");

  irq_follows_a: assert property (
    ##1 port1_irq_o == |(st_r.port[0].pin_irq_flag &
      st_r.port[0].pin_irq_enable))
    else $error("port 1 request not flag and enable");

  one_cycle_ack_a: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");

  dir2_drives_oe_a: assert property (
    !$past(ext_resistor_osc_select_i) |->
      pin2_oe_n_o == ~$past(st_r.port[1].pin_direction[PORT2_PINS-1:0]))
    else $error("port 2 enable not from direction bit");

  p1_hi_compare_a: assert property (
    $past(st_r.port[0].pin_function_select[6]) |->
      pin1_out_o[6] == $past(compare_output_1_i))
    else $error("port 1 bit 6 not compare 1");

  p2_aux_clock_a: assert property (
    $past(st_r.port[1].pin_function_select[0]) |->
      pin2_out_o[0] == $past(aux_clock_i))
    else $error("port 2 bit 0 not auxiliary clock");

  p2_compare_a: assert property (
    $past(st_r.port[1].pin_function_select[4]) |->
      pin2_out_o[4] == $past(compare_output_2_i))
    else $error("port 2 bit 4 not compare 2");

  cap_a_gate_a: assert property (
    capture_in_ch0_a_o == $past(st_r.port[0].pin_function_select[1] &
      st_r.sync[0][1]))
    else $error("capture A 0 not gated by function select");

  cap_b_gate_a: assert property (
    capture_in_ch1_b_o == $past(st_r.port[1].pin_function_select[3] &
      st_r.sync[1][3]))
    else $error("capture B 1 not gated by function select");

  unbonded_low_a: assert property (
    $past(st_r.port[1].pin_function_select[7]) |-> !st_r.pin_out[1][7])
    else $error("unbonded bit 7 module output not low");

  osc_no_input_a: assert property (
    $past(ext_resistor_osc_select_i) |-> !st_r.meta[1][OSC_RES_BIT])
    else $error("cut port 2 bit 5 still feeds the input");

  fall_sets_flag_a: assert property (
    ($fell(pin1_in_i[0]) && st_r.port[0].pin_edge_select[0])
    ##1 (!pin1_in_i[0] && st_r.port[0].pin_edge_select[0]) [*2]
    |-> ##1 st_r.port[0].pin_irq_flag[0])
    else $error("falling edge did not set flag");

  read_high_zero_a: assert property (
    avs_readdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

endmodule // dual_port_pin_function_mux

/* File: hdl/pin_mux_pkg.sv */
// Constants and types shared by the dual port pin function block
package pin_mux_pkg;

  // Register index within one port, word addressed
  localparam logic [2:0] REG_INPUT = 3'h0;
  localparam logic [2:0] REG_OUTPUT = 3'h1;
  localparam logic [2:0] REG_DIRECTION = 3'h2;
  localparam logic [2:0] REG_IRQ_FLAG = 3'h3;
  localparam logic [2:0] REG_EDGE_SELECT = 3'h4;
  localparam logic [2:0] REG_IRQ_ENABLE = 3'h5;
  localparam logic [2:0] REG_FUNCTION_SELECT = 3'h6;
  // Word address bit that selects port 2
  localparam int PORT_ADDR_BIT = 3;
  localparam int ADDR_WIDTH = 4;

  localparam int PORT_WIDTH = 8;
  localparam int PORT2_PINS = 6;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [31:0] READ_DEFAULT = 32'h0000_0000;
  // Port 2 bits that can be set by a pad edge; 6 and 7 have no pad
  localparam logic [7:0] PORT2_EDGE_MASK = 8'h3f;
  // Bit 5 of port 2 that is taken over by the oscillator resistor
  localparam int OSC_RES_BIT = 5;

  typedef struct packed {
    logic [7:0] pin_function_select;
    logic [7:0] pin_direction;
    logic [7:0] pin_output_value;
    logic [7:0] pin_irq_flag;
    logic [7:0] pin_edge_select;
    logic [7:0] pin_irq_enable;
  } port_ctl_type;

  typedef struct packed {
    logic timer_ext_clock_in;
    logic timer_alt_clock_in;
    logic [2:0] capture_in_a;
    logic [1:0] capture_in_b;
  } timer_in_type;

  typedef struct packed {
    port_ctl_type [1:0] port;
    logic [1:0][7:0] meta;
    logic [1:0][7:0] sync;
    logic [1:0][7:0] prev;
    logic [1:0][7:0] pin_out;
    logic [1:0][7:0] pin_oe_n;
    timer_in_type timer;
    logic [1:0] irq;
    logic waitrequest;
    logic [31:0] readdata;
  } state_type;

endpackage

/* File: verif/pin_partner.sv */
// Far-side model: outside pad drivers, timer and clock module sources
`timescale 1ns/100ps
module pin_partner (
  // Bench controls
  input wire logic clk_i,
  input wire logic [7:0] ext1_i,
  input wire logic [5:0] ext2_i,
  input wire logic [4:0] src_i,
  // Design pads
  input wire logic [7:0] pin1_out_i,
  input wire logic [7:0] pin1_oe_n_i,
  input wire logic [5:0] pin2_out_i,
  input wire logic [5:0] pin2_oe_n_i,
  output logic [7:0] pin1_in_o,
  output logic [5:0] pin2_in_o,
  // Module sources, same clock domain as the design
  output logic [2:0] cmp_o,
  output logic sub_clk_o,
  output logic aux_clk_o
);
  // Sources move only at edges, so each level lasts whole cycles
  always_ff @(posedge clk_i) begin
    {aux_clk_o, sub_clk_o, cmp_o} <= src_i;
  end
  // A driven pad shows the design's value, an undriven one the outside
  assign pin1_in_o = (pin1_oe_n_i & ext1_i) | (~pin1_oe_n_i & pin1_out_i);
  assign pin2_in_o = (pin2_oe_n_i & ext2_i) | (~pin2_oe_n_i & pin2_out_i);
endmodule // pin_partner

/* File: verif/dual_port_pin_function_mux_tb.sv */
// Self-checking bench for the dual port pin function block
`timescale 1ns/100ps
module dual_port_pin_function_mux_tb import pin_mux_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [7:0] ext1 = 8'h00;
  logic [5:0] ext2 = 6'h00;
  logic [4:0] src = 5'h00;
  logic ers = 1'b0;
  logic [31:0] q;
  wire [31:0] rdat;
  wire wait_r, irq1, irq2, sub, aux;
  wire [7:0] p1o, p1oe, p1i;
  wire [5:0] p2o, p2oe, p2i;
  wire [2:0] cmp;
  wire [6:0] tin;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #4 clk_i = ~clk_i;

  dual_port_pin_function_mux u_dut (
    .clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd_en), .avs_write_i(wr_en),
    .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r),
    .pin1_in_i(p1i), .pin1_out_o(p1o), .pin1_oe_n_o(p1oe),
    .pin2_in_i(p2i), .pin2_out_o(p2o), .pin2_oe_n_o(p2oe),
    .compare_output_0_i(cmp[0]), .compare_output_1_i(cmp[1]),
    .compare_output_2_i(cmp[2]), .subsystem_clock_i(sub),
    .aux_clock_i(aux), .ext_resistor_osc_select_i(ers),
    .timer_ext_clock_in_o(tin[6]), .timer_alt_clock_in_o(tin[2]),
    .capture_in_ch0_a_o(tin[3]), .capture_in_ch1_a_o(tin[4]),
    .capture_in_ch2_a_o(tin[5]), .capture_in_ch0_b_o(tin[0]),
    .capture_in_ch1_b_o(tin[1]), .port1_irq_o(irq1), .port2_irq_o(irq2)
  );

  pin_partner u_far (
    .clk_i(clk_i), .ext1_i(ext1), .ext2_i(ext2), .src_i(src),
    .pin1_out_i(p1o), .pin1_oe_n_i(p1oe), .pin2_out_i(p2o),
    .pin2_oe_n_i(p2oe), .pin1_in_o(p1i), .pin2_in_o(p2i),
    .cmp_o(cmp), .sub_clk_o(sub), .aux_clk_o(aux)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Request held until waitrequest is seen low; the watchdog ends a hang
  task automatic bus(input logic p, input logic [2:0] r, input logic w,
                     input logic [7:0] d);
    @(posedge clk_i);
    adr <= {p, r};
    wr_en <= w;
    rd_en <= ~w;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (wait_r !== 1'b0) @(posedge clk_i);
    q = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic p, input logic [2:0] r, input logic [7:0] d);
    bus(p, r, 1'b1, d);
  endtask

  task automatic rd(input logic p, input logic [2:0] r, input logic [7:0] e);
    bus(p, r, 1'b0, 8'h00);
    chk(q, {24'h0, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      $display("wrong value at %0t: timeout", $time);
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(5);
    rst_i <= 1'b0;
    for (int i = 0; i < 16; i++) rd(i[3], i[2:0], 8'h00);
    chk(p1oe, 8'hff);
    be <= 4'h0;
    wr(0, REG_OUTPUT, 8'h5a);
    be <= 4'hf;
    rd(0, REG_OUTPUT, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(p[0], REG_OUTPUT, 8'hff);
      wr(p[0], REG_DIRECTION, 8'hff);
      wr(p[0], REG_FUNCTION_SELECT, p ? 8'h1f : 8'hff);
    end
    for (int k = 0; k < 2; k++) begin
      src <= k ? 5'h12 : 5'h0d;
      tick(4);
      chk(p1o, k ? 8'h44 : 8'hba);
      chk(p2o, k ? 6'h29 : 6'h34);
    end
    wr(0, REG_DIRECTION, 8'h0f);
    tick(2);
    chk(p1oe, 8'hf0);
    chk(p2oe, 6'h00);
    wr(0, REG_DIRECTION, 8'h00);
    wr(1, REG_DIRECTION, 8'h00);
    {ext1, ext2} <= {8'h0f, 6'h0e};
    tick(6);
    chk(tin, 7'h7f);
    {ext1, ext2} <= {8'hf4, 6'h3a};
    tick(6);
    chk(tin, 7'h16);
    wr(0, REG_FUNCTION_SELECT, 8'h00);
    wr(1, REG_FUNCTION_SELECT, 8'h00);
    tick(3);
    chk(tin, 7'h00);
    // Cut pad: outside edges on bit 5 must stay invisible
    {ers, ext1, ext2} <= {1'b1, 8'h00, 6'h00};
    wr(1, REG_DIRECTION, 8'h20);
    wr(1, REG_OUTPUT, 8'h20);
    tick(6);
    wr(1, REG_IRQ_FLAG, 8'h00);
    ext2 <= 6'h20;
    tick(6);
    chk({p2o[5], p2oe[5]}, 2'b01);
    rd(1, REG_INPUT, 8'h00);
    rd(1, REG_IRQ_FLAG, 8'h00);
    {ers, ext2} <= {1'b0, 6'h00};
    for (int j = 1; j < 7; j++) begin
      if (j[2:0] != REG_IRQ_FLAG) begin
        wr(1, j[2:0], 8'hc0);
        rd(1, j[2:0], 8'hc0);
      end
    end
    tick(6);
    wr(1, REG_IRQ_FLAG, 8'h00);
    ext2 <= 6'h1f;
    tick(6);
    rd(1, REG_IRQ_FLAG, 8'h1f);
    chk(irq2, 1'b0);
    wr(1, REG_IRQ_FLAG, 8'hc0);
    tick(2);
    chk(irq2, 1'b1);
    rd(1, REG_IRQ_FLAG, 8'hc0);
    wr(0, REG_IRQ_ENABLE, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wr(0, REG_EDGE_SELECT, {7'h0, k != 0});
      wr(0, REG_IRQ_FLAG, 8'h00);
      ext1 <= {7'h0, k != 1};
      tick(6);
      rd(0, REG_IRQ_FLAG, {7'h0, k < 2});
      chk(irq1, k < 2);
    end
    stop_test();
  end
endmodule // dual_port_pin_function_mux_tb
